//--- src/source_port_signal_control.sv
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Orientation low when CC1 terminated, else high
// - Switch-on output closes the bus load switch
// - Switch on only in attached source state
// - Bleed output discharges the bus rail
// - External fault: open switch, bleed, recover
// - Fault line defaults to driven output
// - Internal fault: open-drain low pulse, then input
// - Serial clock never above 8 MHz
// - Companion select low only during transfer
// - Service request triggers a serial transfer
module source_port_signal_control #(
  parameter int unsigned BLEED_CYCLES = psc_pkg::BLEED_CYC,
  parameter int unsigned RECOV_CYCLES = psc_pkg::RECOV_CYC,
  parameter int unsigned PULSE_CYCLES = psc_pkg::PULSE_CYC
) (
  input  wire logic           CLK,
  input  wire logic           NRST,
  input  wire psc_pkg::addr_t ADDR,
  input  wire psc_pkg::word_t WDATA,
  input  wire logic           WR,
  input  wire logic           RD,
  output var  psc_pkg::word_t RDATA,
  input  wire logic           FAULT_LINE_IN,
  output var  logic           SHARED_FAULT_LINE_OUT,
  output var  logic           SHARED_FAULT_LINE_OE,
  output var  logic           SHARED_FAULT_LINE_PD,
  output var  logic           ORIENT_N,
  output var  logic           BUS_POWER_SWITCH_ON,
  output var  logic           BUS_POWER_BLEED,
  output var  logic           SPI_SCK,
  output var  logic           SPI_MOSI,
  input  wire logic           SPI_MISO,
  output var  logic           SPI_SS_N,
  input  wire logic           SPI_IRQ_N
);
  import psc_pkg::*;

  if (BLEED_CYCLES < 1 || BLEED_CYCLES > 20'hfffff ||
      RECOV_CYCLES < 8 || RECOV_CYCLES > 20'hfffff ||
      PULSE_CYCLES < 1 || PULSE_CYCLES > 20'hfffff) begin : g_chk
    $error("Cycle counts out of range for 20-bit counters");
  end
  if (SPI_HALF_CYC < 1 || SPI_HALF_CYC > 16) begin : g_chk_spi
    $error("Serial half period does not fit its divider");
  end
  // A pulse still running after recovery would read back as an external fault
  if (PULSE_CYCLES + 8 > BLEED_CYCLES + RECOV_CYCLES) begin : g_chk_pulse
    $error("Fault pulse must end well before recovery completes");
  end

  state_s r;
  state_s n;
  logic   ext_flt;
  logic   wr_ctrl;
  logic   start;
  logic   tick;

  // Change is accepted only once stages two and three agree
  function automatic sync_s sync_step(sync_s s, logic pin);
    sync_s o;
    o    = s;
    o.s1 = pin;
    o.s2 = s.s1;
    o.s3 = s.s2;
    if (s.s2 == s.s3) begin
      o.f = s.s3;
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n      = r;
    n.fi   = sync_step(r.fi, FAULT_LINE_IN);
    n.irq  = sync_step(r.irq, SPI_IRQ_N);
    n.miso = sync_step(r.miso, SPI_MISO);
    wr_ctrl = WR && ADDR == CTRL_OFS;

    // Our own low drive and the forwarded fault must not read back as external
    ext_flt = !r.fi.f && !(r.f_oe && !r.f_out) &&
              (r.conn == C_DET || r.conn == C_ATT);

    if (wr_ctrl) begin
      n.attach    = WDATA[CTRL_ATTACH];
      n.cc1       = WDATA[CTRL_CC1];
      n.bleed_req = WDATA[CTRL_BLEED];
      n.svc_en    = WDATA[CTRL_SVC_EN];
    end

    case (r.conn)
      C_DET: begin
        if (ext_flt) begin
          n.conn = C_SAFE;
          n.cnt  = 20'(BLEED_CYCLES - 1);
        end else if (r.attach) begin
          n.conn = C_ATT;
        end
      end
      C_ATT: begin
        if (ext_flt) begin
          n.conn = C_SAFE;
          n.cnt  = 20'(BLEED_CYCLES - 1);
        end else if (!r.attach) begin
          n.conn = C_DET;
        end
      end
      C_SAFE: begin
        if (r.cnt == 20'h0) begin
          n.conn = C_RECOV;
          n.cnt  = 20'(RECOV_CYCLES - 1);
        end else begin
          n.cnt = r.cnt - 20'h1;
        end
      end
      C_RECOV: begin
        if (r.cnt == 20'h0) begin
          n.conn = C_DET;
        end else begin
          n.cnt = r.cnt - 20'h1;
        end
      end
      default: begin
        n.conn = C_DET;
      end
    endcase

    case (r.fmode)
      F_PULSE: begin
        if (r.pcnt == 20'h0) begin
          n.fmode = F_IN;
        end else begin
          n.pcnt = r.pcnt - 20'h1;
        end
      end
      F_IN: begin
        if (wr_ctrl && WDATA[CTRL_REARM]) begin
          n.fmode = F_OUT;
        end
      end
      F_OUT: begin
        n.fmode = F_OUT;
      end
      default: begin
        n.fmode = F_IN;
      end
    endcase

    // A repeat internal fault during the pulse does not stretch it
    if (wr_ctrl && WDATA[CTRL_INTFLT] && r.fmode != F_PULSE) begin
      n.fmode = F_PULSE;
      n.pcnt  = 20'(PULSE_CYCLES - 1);
      n.conn  = C_SAFE;
      n.cnt   = 20'(BLEED_CYCLES - 1);
    end

    // Set wins over a write-one clear in the same cycle
    if (WR && ADDR == STATUS_OFS && WDATA[ST_FLT]) begin
      n.flt_seen = 1'b0;
    end
    if (ext_flt || (wr_ctrl && WDATA[CTRL_INTFLT])) begin
      n.flt_seen = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial master, mode 0, one byte per select window
    if (WR && ADDR == TX_OFS) begin
      n.tx = WDATA[7:0];
    end
    start = !r.busy && ((WR && ADDR == TX_OFS) || (r.svc_en && !r.irq.f));
    tick  = r.div == 4'h0;
    if (start) begin
      n.busy = 1'b1;
      n.ss_n = 1'b0;
      n.sck  = 1'b0;
      n.div  = 4'(SPI_HALF_CYC - 1);
      n.bits = 4'h0;
      n.sh   = (WR && ADDR == TX_OFS) ? WDATA[7:0] : r.tx;
      n.mosi = n.sh[7];
    end else if (r.busy) begin
      if (!tick) begin
        n.div = r.div - 4'h1;
      end else begin
        n.div = 4'(SPI_HALF_CYC - 1);
        if (r.bits == 4'(SPI_TAIL)) begin
          n.busy = 1'b0;
          n.ss_n = 1'b1;
          n.rx   = r.sh;
        end else if (!r.sck) begin
          n.sck  = 1'b1;
          n.sh   = {r.sh[6:0], r.miso.f};
          n.bits = r.bits + 4'h1;
        end else begin
          n.sck  = 1'b0;
          n.mosi = r.sh[7];
          if (r.bits == 4'(SPI_LAST_EDGE)) begin
            n.bits = 4'(SPI_TAIL);
          end
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin values, computed from the next state
    n.sw_on    = n.conn == C_ATT;
    n.bleed    = n.conn == C_SAFE || (n.bleed_req && !n.sw_on);
    n.orient_n = !n.cc1;
    n.f_oe     = n.fmode != F_IN;
    n.f_pd     = n.fmode == F_PULSE;
    n.f_out    = !(n.fmode == F_PULSE || n.conn == C_SAFE);

    n.rdata = '0;
    if (RD) begin
      case (ADDR)
        CTRL_OFS: begin
          n.rdata[CTRL_ATTACH] = r.attach;
          n.rdata[CTRL_CC1]    = r.cc1;
          n.rdata[CTRL_BLEED]  = r.bleed_req;
          n.rdata[CTRL_SVC_EN] = r.svc_en;
        end
        STATUS_OFS: begin
          n.rdata[ST_SW_ON]                 = r.sw_on;
          n.rdata[ST_BLEED]                 = r.bleed;
          n.rdata[ST_FLT]                   = r.flt_seen;
          n.rdata[ST_BUSY]                  = r.busy;
          n.rdata[ST_IRQ]                   = !r.irq.f;
          n.rdata[ST_LINE]                  = r.fi.f;
          n.rdata[ST_CONN_LO+1:ST_CONN_LO]  = r.conn;
          n.rdata[ST_MODE_LO+1:ST_MODE_LO]  = r.fmode;
        end
        TX_OFS: begin
          n.rdata[7:0] = r.tx;
        end
        RX_OFS: begin
          n.rdata[7:0] = r.rx;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end

    // Idle levels: clock and data low, select high, fault line driven high
    if (!NRST) begin
      n          = '0;
      n.conn     = C_DET;
      n.fmode    = F_OUT;
      n.fi       = '1;
      n.irq      = '1;
      n.orient_n = 1'b1;
      n.f_out    = 1'b1;
      n.f_oe     = 1'b1;
      n.ss_n     = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    r <= n;
  end

  assign RDATA                 = r.rdata;
  assign SHARED_FAULT_LINE_OUT = r.f_out;
  assign SHARED_FAULT_LINE_OE  = r.f_oe;
  assign SHARED_FAULT_LINE_PD  = r.f_pd;
  assign ORIENT_N              = r.orient_n;
  assign BUS_POWER_SWITCH_ON   = r.sw_on;
  assign BUS_POWER_BLEED       = r.bleed;
  assign SPI_SCK               = r.sck;
  assign SPI_MOSI              = r.mosi;
  assign SPI_SS_N              = r.ss_n;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [19:0] plen;
  always_ff @(posedge CLK) begin
    if (!NRST || r.fmode != F_PULSE) begin
      plen <= 20'h0;
    end else begin
      plen <= plen + 20'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  orient_follows_a: assert property (
    wr_ctrl |=> ORIENT_N == !$past(WDATA[CTRL_CC1]))
    else $error("orientation does not follow the written CC select");

  switch_attached_a: assert property (
    BUS_POWER_SWITCH_ON == (r.conn == C_ATT))
    else $error("switch on outside attached state");

  switch_closes_a: assert property (
    (r.conn == C_DET && r.attach && !ext_flt && !(wr_ctrl && WDATA[CTRL_INTFLT]))
      |=> BUS_POWER_SWITCH_ON)
    else $error("switch not closed on attach");

  fault_safe_a: assert property (
    (r.conn == C_ATT && ext_flt) |=> (!BUS_POWER_SWITCH_ON && BUS_POWER_BLEED
      && r.conn == C_SAFE) ##1 (r.conn != C_ATT))
    else $error("external fault did not make the bus safe");

  bleed_safe_a: assert property (
    (r.conn == C_SAFE) |-> BUS_POWER_BLEED && !BUS_POWER_SWITCH_ON)
    else $error("no discharge while safe");

  line_default_a: assert property (
    (r.fmode == F_OUT) |-> SHARED_FAULT_LINE_OE && !SHARED_FAULT_LINE_PD)
    else $error("fault line not driven in output mode");

  pulse_drive_a: assert property (
    (r.fmode == F_PULSE) |-> SHARED_FAULT_LINE_OE && !SHARED_FAULT_LINE_OUT
      && SHARED_FAULT_LINE_PD)
    else $error("fault pulse not driven low with pull-down");

  pulse_len_a: assert property (
    $fell(r.fmode == F_PULSE) |-> plen == 20'(PULSE_CYCLES) && !SHARED_FAULT_LINE_OE)
    else $error("fault pulse length wrong or line not released");

  sck_rate_a: assert property (
    $rose(SPI_SCK) |-> SPI_SCK [*8])
    else $error("serial clock high phase too short");

  select_window_a: assert property (
    $changed(SPI_SCK) |-> !SPI_SS_N && !$past(SPI_SS_N))
    else $error("serial clock moved outside select");

  service_start_a: assert property (
    (r.svc_en && !r.irq.f && !r.busy) |=> !SPI_SS_N && r.busy)
    else $error("service request not answered");

  sync_agree_a: assert property (
    $fell(r.fi.f) |-> !r.fi.s3 && !$past(r.fi.s3))
    else $error("fault input accepted before stages agreed");

  attach_c: cover property (r.conn == C_DET ##1 r.conn == C_ATT);
  ext_fault_c: cover property (r.conn == C_ATT && ext_flt);
  spi_done_c: cover property ($rose(SPI_SS_N) ##1 r.rx != 8'h0);
  pulse_c: cover property ($fell(r.fmode == F_PULSE));

endmodule

`default_nettype wire

//--- src/psc_pkg.sv
package psc_pkg;

  typedef logic [3:0]  addr_t;
  typedef logic [31:0] word_t;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets and fields
  localparam addr_t CTRL_OFS   = 4'h0;
  localparam addr_t STATUS_OFS = 4'h4;
  localparam addr_t TX_OFS     = 4'h8;
  localparam addr_t RX_OFS     = 4'hc;

  localparam int CTRL_ATTACH = 0;
  localparam int CTRL_CC1    = 1;
  localparam int CTRL_BLEED  = 2;
  localparam int CTRL_SVC_EN = 3;
  localparam int CTRL_INTFLT = 4;
  localparam int CTRL_REARM  = 5;

  localparam int ST_SW_ON   = 0;
  localparam int ST_BLEED   = 1;
  localparam int ST_FLT     = 2;
  localparam int ST_BUSY    = 3;
  localparam int ST_IRQ     = 4;
  localparam int ST_LINE    = 5;
  localparam int ST_CONN_LO = 6;
  localparam int ST_MODE_LO = 8;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ        = 125;
  localparam int CLK_KHZ        = 125000;
  localparam int SPI_FMAX_KHZ   = 8000;
  localparam int SPI_HALF_CYC   = (CLK_KHZ + 2 * SPI_FMAX_KHZ - 1) / (2 * SPI_FMAX_KHZ);
  localparam int BLEED_TIME_US  = 1000;
  localparam int BLEED_CYC      = BLEED_TIME_US * CLK_MHZ;
  localparam int RECOV_TIME_US  = 1000;
  localparam int RECOV_CYC      = RECOV_TIME_US * CLK_MHZ;
  localparam int PULSE_TIME_US  = 1000;
  localparam int PULSE_CYC      = PULSE_TIME_US * CLK_MHZ;
  localparam int SPI_LAST_EDGE  = 8;
  localparam int SPI_TAIL       = 9;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    C_DET   = 2'b00,
    C_ATT   = 2'b01,
    C_SAFE  = 2'b10,
    C_RECOV = 2'b11
  } conn_e;

  typedef enum logic [1:0] {
    F_OUT   = 2'b00,
    F_PULSE = 2'b01,
    F_IN    = 2'b10
  } fmode_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
  } sync_s;

  typedef struct packed {
    sync_s       fi;
    sync_s       irq;
    sync_s       miso;
    conn_e       conn;
    fmode_e      fmode;
    logic [19:0] cnt;
    logic [19:0] pcnt;
    logic        attach;
    logic        cc1;
    logic        bleed_req;
    logic        svc_en;
    logic        flt_seen;
    logic        busy;
    logic [3:0]  div;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        sw_on;
    logic        bleed;
    logic        orient_n;
    logic        f_out;
    logic        f_oe;
    logic        f_pd;
    logic        sck;
    logic        mosi;
    logic        ss_n;
    word_t       rdata;
  } state_s;

endpackage

//--- testbench/companion_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module companion_model (
  input  wire logic       SCK,
  input  wire logic       MOSI,
  input  wire logic       SS_N,
  input  wire logic [7:0] reply,
  input  wire logic       req,
  output wire logic       MISO,
  output wire logic       IRQ_N,
  output var  logic [7:0] got
);
  logic [7:0] sh = 8'h00;
  initial got = 8'h00;
  assign IRQ_N = !req;
  assign MISO  = sh[7];
  always @(negedge SS_N) sh = reply;
  // Deselected, the line flips so a stale bit never reads as valid
  always @(posedge SS_N) sh = ~sh;
  always @(posedge SCK) if (!SS_N) got = {got[6:0], MOSI};
  always @(negedge SCK) if (!SS_N) sh = {sh[6:0], ~sh[7]};
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import psc_pkg::*;
  localparam int BLEED_N = 20;
  localparam int RECOV_N = 10;
  localparam int PULSE_N = 16;
  localparam int LIMIT   = 20000;
  logic       clk = 0, nrst = 0, wr = 0, rd = 0, ext_fault = 0, req = 0;
  logic       rd_d = 0, sck_p = 0;
  addr_t      addr = 4'h0;
  word_t      wdata = 32'h0, rdata, expq[$], maskq[$];
  logic [7:0] reply = 8'h00, got;
  logic [31:0] seed = 32'hbc508136;
  int         errors = 0, comparisons = 0, cyc = 0, gap = 0;
  logic       fo, foe, fpd, orient_n, sw_on, bleed, sck, mosi, miso, ss_n, irq_n, pin;

  always #4 clk = ~clk;
  // Pull-up wins unless any party pulls low
  assign pin = !(ext_fault || (foe && !fo));

  source_port_signal_control #(
    .BLEED_CYCLES(BLEED_N), .RECOV_CYCLES(RECOV_N), .PULSE_CYCLES(PULSE_N)
  ) dut_u (
    .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .FAULT_LINE_IN(pin), .SHARED_FAULT_LINE_OUT(fo),
    .SHARED_FAULT_LINE_OE(foe), .SHARED_FAULT_LINE_PD(fpd), .ORIENT_N(orient_n),
    .BUS_POWER_SWITCH_ON(sw_on), .BUS_POWER_BLEED(bleed), .SPI_SCK(sck),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_SS_N(ss_n), .SPI_IRQ_N(irq_n)
  );
  companion_model partner_u (
    .SCK(sck), .MOSI(mosi), .SS_N(ss_n), .reply(reply), .req(req),
    .MISO(miso), .IRQ_N(irq_n), .got(got)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return sw_on;
      1: return bleed;
      2: return ss_n;
      default: return fpd;
    endcase
  endfunction
  task automatic check(input word_t g, input word_t e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input addr_t a, input word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input addr_t a, input word_t m, input word_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    maskq.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Bounded wait; a miss shows as a mismatch of the awaited level
  task automatic wait_until(input int w, input logic v, input int max);
    int k;
    for (k = 0; k < max && sig(w) !== v; k++) @(negedge clk);
    check(word_t'(sig(w)), word_t'(v));
  endtask
  task automatic summarize();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) check(rdata & maskq.pop_front(), expq.pop_front());
    sck_p <= sck;
    gap <= (sck != sck_p) ? 1 : gap + 1;
    // Half period of at least 8 cycles keeps the clock under 8 MHz
    if (sck != sck_p) check(word_t'(gap >= 8 && !ss_n), 32'h1);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      summarize();
    end
  end

  initial begin
    int i;
    int n;
    logic [7:0] tx;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(word_t'({fo, foe, fpd, orient_n, sw_on, bleed, ss_n, sck}), 32'hd2);
    rd_reg(4'h2, 32'hffffffff, 32'h0);
    rd_reg(STATUS_OFS, 32'h3ff, 32'h20);
    $display("test reset done");
    wr_reg(CTRL_OFS, 32'h2);
    @(negedge clk);
    check(word_t'(orient_n), 32'h0);
    wr_reg(CTRL_OFS, 32'h4);
    wait_until(1, 1'b1, 4);
    wr_reg(CTRL_OFS, 32'h1);
    @(negedge clk);
    check(word_t'({orient_n, sw_on}), 32'h2);
    @(negedge clk);
    check(word_t'({sw_on, bleed}), 32'h2);
    rd_reg(STATUS_OFS, 32'hc3, 32'h41);
    $display("test attach done");
    @(posedge clk);
    ext_fault <= 1'b1;
    wait_until(0, 1'b0, 10);
    check(word_t'({bleed, fo}), 32'h2);
    @(posedge clk);
    ext_fault <= 1'b0;
    for (n = 1; bleed === 1'b1 && n < 100; n++) @(negedge clk);
    check(word_t'(n >= BLEED_N - 1 && n <= BLEED_N + 1), 32'h1);
    check(word_t'(sw_on), 32'h0);
    wait_until(0, 1'b1, RECOV_N + 8);
    rd_reg(STATUS_OFS, 32'h4, 32'h4);
    wr_reg(STATUS_OFS, 32'h4);
    rd_reg(STATUS_OFS, 32'h4, 32'h0);
    $display("test external fault done");
    wr_reg(CTRL_OFS, 32'h11);
    @(negedge clk);
    check(word_t'({foe, fo, fpd}), 32'h5);
    for (n = 1; fpd === 1'b1 && n < 100; n++) @(negedge clk);
    check(word_t'(n >= PULSE_N - 1 && n <= PULSE_N + 1), 32'h1);
    check(word_t'(foe), 32'h0);
    wait_until(0, 1'b1, BLEED_N + RECOV_N + 20);
    wr_reg(CTRL_OFS, 32'h21);
    @(negedge clk);
    check(word_t'(foe), 32'h1);
    $display("test internal fault done");
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tx = seed[7:0];
      @(posedge clk);
      reply <= seed[15:8];
      wr_reg(TX_OFS, {24'h0, tx});
      if (i == 0) wr_reg(TX_OFS, {24'h0, ~tx});
      wait_until(2, 1'b0, 4);
      wait_until(2, 1'b1, 200);
      check(word_t'(got), word_t'(tx));
      rd_reg(RX_OFS, 32'hff, word_t'(reply));
      check(word_t'(ss_n), 32'h1);
    end
    $display("test serial done");
    wr_reg(CTRL_OFS, 32'h9);
    @(posedge clk);
    req <= 1'b1;
    wait_until(2, 1'b0, 10);
    @(posedge clk);
    req <= 1'b0;
    wait_until(2, 1'b1, 200);
    check(word_t'(got), word_t'(tx));
    $display("test service done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(word_t'({foe, fpd, sw_on, bleed, ss_n}), 32'h11);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(negedge clk);
    check(word_t'({fo, foe, fpd, orient_n, sw_on, bleed, ss_n, sck}), 32'hd2);
    rd_reg(STATUS_OFS, 32'h3ff, 32'h20);
    rd_reg(CTRL_OFS, 32'hf, 32'h0);
    repeat (2) @(posedge clk);
    $display("test reset again done");
    summarize();
  end
endmodule
`default_nettype wire
